// ===== bench/latch_host_model.sv
// Host model that shifts words into the loader and pulses the strobe.
`timescale 1ns/1ps
module latch_host_model (
    input  wire logic clk_i,
    output logic      serial_clk_o,
    output logic      serial_data_o,
    output logic      load_strobe_o
);
    initial begin
        serial_clk_o  = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    // The serial clock idles low, and data flips once the frame ends.
    task automatic send_word(input logic [23:0] word);
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk_i);
            serial_data_o = word[i];
            repeat (7) @(negedge clk_i);
            serial_clk_o = 1'b1;
            repeat (8) @(negedge clk_i);
            serial_clk_o = 1'b0;
        end
        serial_data_o = ~word[0];
        repeat (4) @(negedge clk_i);
        load_strobe_o = 1'b1;
        repeat (8) @(negedge clk_i);
        load_strobe_o = 1'b0;
    endtask
endmodule // latch_host_model

// ===== bench/three_wire_latch_loader_tb_top.sv
// Random word loads with checks of latches, power state and monitor.
`timescale 1ns/1ps
module three_wire_latch_loader_tb_top;
    logic        clk_i = 0, reset_i = 1, ce = 0, lock = 0, rfd = 0, rfr = 0;
    logic        sclk, sdat, strobe, pwr, pump, mon;
    logic [23:0] lat [4];
    logic [23:0] expl [4];
    logic [1:0]  order [3] = '{2'h1, 2'h0, 2'h2};
    logic [23:0] w;
    int          bad_count = 0, tests_run = 0, seed = 32'hcc08594f;
    always #5 clk_i = ~clk_i;
    latch_host_model i_latch_host_model (.clk_i(clk_i),
        .serial_clk_o(sclk), .serial_data_o(sdat), .load_strobe_o(strobe));
    three_wire_latch_loader i_three_wire_latch_loader (.clk_i(clk_i),
        .reset_i(reset_i), .serial_clk_i(sclk), .serial_data_i(sdat),
        .load_strobe_i(strobe), .chip_enable_i(ce), .lock_detect_i(lock),
        .rf_div_i(rfd), .ref_div_i(rfr), .control_latch_o(lat[0]),
        .reference_latch_o(lat[1]), .feedback_latch_o(lat[2]),
        .test_latch_o(lat[3]), .powered_up_o(pwr),
        .pump_output_en_o(pump), .monitor_output_o(mon));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic mon_exp(input logic [2:0] s);
        case (s)
            3'h1: return lock;
            3'h2: return rfd;
            3'h3: return 1'b1;
            3'h4: return rfr;
            default: return 1'b0;
        endcase
    endfunction
    task automatic load(input logic [23:0] word);
        i_latch_host_model.send_word(word);
        expl[word[1:0]] = word;
        repeat (10) @(negedge clk_i);
        for (int k = 0; k < 4; k++) check(lat[k], expl[k]);
        check({23'h0, pwr}, {23'h0, ce & ~|expl[0][21:20]});
        check({23'h0, pump}, {23'h0, ce & ~|expl[0][21:20]});
        check({23'h0, mon}, {23'h0, mon_exp(expl[0][7:5])});
    endtask
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        for (int k = 0; k < 4; k++) expl[k] = 24'h000000;
        repeat (5) @(negedge clk_i);
        reset_i = 0;
        // Power-up order first. The host never writes the test latch, so it
        // must stay at its reset value whatever the other codes do.
        for (int n = 0; n < 24; n++) begin
            w = 24'($random(seed));
            w[1:0] = order[n % 3];
            if (n < 15) w[21:20] = 2'h0;
            if (n < 15) w[7:5] = 3'(n / 3);
            {ce, lock, rfd, rfr} = 4'($random(seed));
            load(w);
        end
        // Corners: both power-down bits, then one alone, with enable high.
        ce = 1'b1;
        load(24'h300060);
        load(24'h100080);
        // A reset in mid-run clears every latch and loading resumes at once.
        reset_i = 1'b1;
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        for (int k = 0; k < 4; k++) expl[k] = 24'h000000;
        load(24'h000025);
        stop_test();
    end
endmodule // three_wire_latch_loader_tb_top

// ===== hdl/latch_loader_pkg.sv
// Constants shared by the three-wire latch loader.
package latch_loader_pkg;
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_CONTROL   = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK  = 2'h2;
    localparam logic [1:0] SEL_TEST      = 2'h3;
    // Control latch power-down bits and monitor select field positions.
    localparam int PD1_BIT      = 20;
    localparam int PD2_BIT      = 21;
    localparam int MON_SEL_LO   = 5;
    localparam logic [2:0] MON_LOW   = 3'h0;
    localparam logic [2:0] MON_LOCK  = 3'h1;
    localparam logic [2:0] MON_RFDIV = 3'h2;
    localparam logic [2:0] MON_HIGH  = 3'h3;
    localparam logic [2:0] MON_REFDIV = 3'h4;
    localparam logic [23:0] LATCH_RESET = 24'h000000;
endpackage

// ===== hdl/three_wire_latch_loader.sv
// Serial shift register, latch loader, power control and monitor mux.
`timescale 1ns/1ps
module three_wire_latch_loader (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         serial_clk_i,
    input  wire logic         serial_data_i,
    input  wire logic         load_strobe_i,
    input  wire logic         chip_enable_i,
    input  wire logic         lock_detect_i,
    input  wire logic         rf_div_i,
    input  wire logic         ref_div_i,
    output logic [23:0]       control_latch_o,
    output logic [23:0]       reference_latch_o,
    output logic [23:0]       feedback_latch_o,
    output logic [23:0]       test_latch_o,
    output logic              powered_up_o,
    output logic              pump_output_en_o,
    output logic              monitor_output_o
);
    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers on every pin but reset. The monitor sources take a third
    // stage so the mux reads a value that has had a full cycle to settle.
    logic [4:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic [4:2] s3_r, s3_nxt;
    logic [4:0] raw;
    assign raw = {ref_div_i, rf_div_i, lock_detect_i,
                  serial_clk_i, serial_data_i};
    // Index 0 data, 1 serial clock; strobe and enable handled below.
    logic [2:1] c1_r, c1_nxt, c2_r, c2_nxt;
    logic       sclk_d_r, sclk_d_nxt, le_d_r, le_d_nxt;
    always_comb begin
        s1_nxt     = raw;
        s2_nxt     = s1_r;
        s3_nxt     = s2_r[4:2];
        c1_nxt     = {chip_enable_i, load_strobe_i};
        c2_nxt     = c1_r;
        sclk_d_nxt = s2_r[1];
        le_d_nxt   = c2_r[1];
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1_r     <= 5'h00;
            s2_r     <= 5'h00;
            s3_r     <= 3'h0;
            c1_r     <= 2'h0;
            c2_r     <= 2'h0;
            sclk_d_r <= 1'b0;
            le_d_r   <= 1'b0;
        end else begin
            s1_r     <= s1_nxt;
            s2_r     <= s2_nxt;
            s3_r     <= s3_nxt;
            c1_r     <= c1_nxt;
            c2_r     <= c2_nxt;
            sclk_d_r <= sclk_d_nxt;
            le_d_r   <= le_d_nxt;
        end
    end
    logic sclk_rise, le_rise;
    assign sclk_rise = s2_r[1] & ~sclk_d_r;
    assign le_rise   = c2_r[1] & ~le_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Shift register and latches. Data is taken with the synchronised clock
    // so both travel the same delay and setup at the pin is preserved.
    logic [23:0] shift_r, shift_nxt;
    logic [23:0] latch_r [4];
    logic [23:0] latch_nxt [4];
    always_comb begin
        shift_nxt = shift_r;
        if (sclk_rise) begin
            shift_nxt = {shift_r[22:0], s2_r[0]};
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            shift_r <= latch_loader_pkg::LATCH_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_latch
            always_comb begin
                latch_nxt[g] = latch_r[g];
                if (le_rise && shift_r[1:0] == 2'(g)) begin
                    latch_nxt[g] = shift_r;
                end
            end
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    latch_r[g] <= latch_loader_pkg::LATCH_RESET;
                end else begin
                    latch_r[g] <= latch_nxt[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Power and monitor outputs, all registered.
    logic [23:0] ctl;
    logic [2:0]  mon_sel;
    logic        pwr_nxt, mon_nxt, pwr_r, mon_r;
    assign ctl     = latch_r[latch_loader_pkg::SEL_CONTROL];
    assign mon_sel = ctl[latch_loader_pkg::MON_SEL_LO +: 3];
    always_comb begin
        // Either power-down bit set keeps the device down.
        pwr_nxt = c2_r[2] & ~ctl[latch_loader_pkg::PD1_BIT]
                          & ~ctl[latch_loader_pkg::PD2_BIT];
        case (mon_sel)
            latch_loader_pkg::MON_LOCK:   mon_nxt = s3_r[2];
            latch_loader_pkg::MON_RFDIV:  mon_nxt = s3_r[3];
            latch_loader_pkg::MON_HIGH:   mon_nxt = 1'b1;
            latch_loader_pkg::MON_REFDIV: mon_nxt = s3_r[4];
            default:                      mon_nxt = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pwr_r   <= 1'b0;
            mon_r   <= 1'b0;
        end else begin
            pwr_r   <= pwr_nxt;
            mon_r   <= mon_nxt;
        end
    end
    assign control_latch_o   = latch_r[0];
    assign reference_latch_o = latch_r[1];
    assign feedback_latch_o  = latch_r[2];
    assign test_latch_o      = latch_r[3];
    assign powered_up_o      = pwr_r;
    assign pump_output_en_o  = pwr_r;
    assign monitor_output_o  = mon_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin to internal edge latency follows from the synchroniser depth.
    a_sclk_latency: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(serial_clk_i) |-> ##[1:3] sclk_rise)
        else $error("serial clock edge not seen in time");
    a_strobe_latency: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(load_strobe_i) |-> ##[1:3] le_rise)
        else $error("load strobe edge not seen in time");
    a_shift_on_edge: assert property (
        @(posedge clk_i) disable iff (reset_i)
        sclk_rise |=> shift_r == {$past(shift_r[22:0]), $past(s2_r[0])})
        else $error("shift register missed a serial clock edge");
    a_shift_holds: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !sclk_rise |=> $stable(shift_r))
        else $error("shift register moved without a clock edge");

    ////////////////////////////////////////////////////////////////////////
    // Latch loading.
    a_load_dest: assert property (
        @(posedge clk_i) disable iff (reset_i)
        le_rise |=> latch_r[$past(shift_r[1:0])] == $past(shift_r))
        else $error("latch not loaded from shift register");
    a_load_sel_ctl: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (le_rise && shift_r[1:0] != latch_loader_pkg::SEL_CONTROL) |=> $stable(latch_r[0]))
        else $error("control latch written with wrong code");
    a_load_sel_ref: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (le_rise && shift_r[1:0] != latch_loader_pkg::SEL_REFERENCE) |=> $stable(latch_r[1]))
        else $error("reference latch written with wrong code");
    a_load_sel_fb: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (le_rise && shift_r[1:0] != latch_loader_pkg::SEL_FEEDBACK) |=> $stable(latch_r[2]))
        else $error("feedback latch written with wrong code");
    a_load_sel_test: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (le_rise && shift_r[1:0] != latch_loader_pkg::SEL_TEST) |=> $stable(latch_r[3]))
        else $error("test latch written with wrong code");
    a_latch_idle: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !le_rise |=> $stable(latch_r[0]) && $stable(latch_r[1])
                     && $stable(latch_r[2]) && $stable(latch_r[3]))
        else $error("latch changed without a load strobe");

    ////////////////////////////////////////////////////////////////////////
    // Power control.
    a_ce_low_down: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !c2_r[2] |=> !pump_output_en_o && !powered_up_o)
        else $error("pump enabled while chip enable low");
    a_ce_fall_down: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $fell(chip_enable_i) |-> ##[1:4] !powered_up_o)
        else $error("device stayed up after chip enable fell");
    a_power_bits: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (c2_r[2] && !ctl[latch_loader_pkg::PD1_BIT]
         && !ctl[latch_loader_pkg::PD2_BIT]) |=> powered_up_o)
        else $error("device failed to power up");
    a_pd_bits_down: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ctl[latch_loader_pkg::PD1_BIT] || ctl[latch_loader_pkg::PD2_BIT])
        |=> !powered_up_o)
        else $error("device up although a power-down bit is set");

    ////////////////////////////////////////////////////////////////////////
    // Monitor mux.
    a_mon_lock: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mon_sel == latch_loader_pkg::MON_LOCK |=> monitor_output_o == $past(s3_r[2]))
        else $error("monitor output not showing lock detect");
    a_mon_rfdiv: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mon_sel == latch_loader_pkg::MON_RFDIV |=> monitor_output_o == $past(s3_r[3]))
        else $error("monitor output not showing scaled RF");
    a_mon_refdiv: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mon_sel == latch_loader_pkg::MON_REFDIV |=> monitor_output_o == $past(s3_r[4]))
        else $error("monitor output not showing scaled reference");
    a_mon_high: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mon_sel == latch_loader_pkg::MON_HIGH |=> monitor_output_o)
        else $error("monitor output not held high");
    a_mon_low: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (mon_sel == latch_loader_pkg::MON_LOW
         || mon_sel > latch_loader_pkg::MON_REFDIV) |=> !monitor_output_o)
        else $error("monitor output not held low");
endmodule // three_wire_latch_loader
